// ==== include/flash_status_pkg.sv ====
package flash_status_pkg;
  // data bus bit positions of the status bits
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int TIMEOUT_BIT = 5;
  localparam int SECTOR_TOGGLE_BIT = 2;
  // bus widths
  localparam int ADDR_W = 20;
  localparam int DATA_W = 8;
  // command port register offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h1;
  localparam logic [3:0] REG_DATA = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_LAST = 4'h4;
  // control register fields
  localparam int CTRL_START = 0;
  localparam int CTRL_MODE = 1;
  localparam int CTRL_RESET = 2;
  // status register fields
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_RDY = 3;
  // reset command code
  localparam logic [7:0] RESET_CODE = 8'hF0;
  // bus cycle timing in ns, rounded up to clocks
  localparam int CLK_NS = 10;
  localparam int STROBE_NS = 70;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int GAP_NS = 30;
  localparam int GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] STROBE_CNT = CNT_W'(STROBE_CYC - 1);
  localparam logic [CNT_W-1:0] GAP_CNT = CNT_W'(GAP_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  // polling sequencer states
  typedef enum logic [7:0] {
    S_IDLE = 8'h01,
    S_RD1 = 8'h02,
    S_RD2 = 8'h04,
    S_RD3 = 8'h08,
    S_DONE = 8'h10,
    S_FAIL = 8'h20,
    S_WRRST = 8'h40,
    S_GAP = 8'h80
  } poll_state_t;
endpackage

// ==== rtl/flash_status_poller.sv ====
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
// Behaviour
// - host reads polling status at the program address
// - host reads erase polling inside a sector selected for erasure
// - after polling bit turns true, host reads again before trusting byte
// - read cycle framed by output strobe or chip select advances toggles
// - host reads twice, compares toggle bit; equal means done
// - toggling with timeout high: check once more, still toggling is failure
// - polling restarts with a fresh double read after interruption
// - data polling re-reads polling bit after seeing timeout bit set
// - single write of code F0 to any address returns to array read
module flash_status_poller
  import flash_status_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // command port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // flash bus
  output logic [ADDR_W-1:0] fl_addr,
  input wire logic [DATA_W-1:0] fl_dq_in,
  output logic [DATA_W-1:0] fl_dq_out,
  output logic fl_dq_oe,
  output logic fl_ce_n,
  output logic fl_oe_n,
  output logic fl_we_n,
  input wire logic ready_busy_n
);

  poll_state_t state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [DATA_W-1:0] exp_q, exp_d;
  logic [DATA_W-1:0] first_q, first_d;
  logic [DATA_W-1:0] last_q, last_d;
  logic mode_q, mode_d;
  logic done_q, done_d;
  logic fail_q, fail_d;
  logic two_q, two_d;
  logic rdy_q;
  logic [31:0] rdata_d;
  logic ce_d, oe_d, we_d, dqoe_d;
  logic [DATA_W-1:0] dqo_d;
  logic strobe_end;
  logic tgl_same;
  logic poll_true;

  assign strobe_end = (cnt_q == CNT_ZERO);
  // compare toggle bit of two successive reads
  assign tgl_same = (first_q[TOGGLE_BIT] == fl_dq_in[TOGGLE_BIT]);
  // polling bit matches the expected true value
  assign poll_true = (fl_dq_in[POLL_BIT] == exp_q[POLL_BIT]);

  always_comb begin
    state_d = state_q;
    cnt_d = strobe_end ? cnt_q : cnt_q - 4'h1;
    addr_d = addr_q;
    exp_d = exp_q;
    first_d = first_q;
    last_d = last_q;
    mode_d = mode_q;
    done_d = done_q;
    fail_d = fail_q;
    two_d = two_q;
    ce_d = 1'b1;
    oe_d = 1'b1;
    we_d = 1'b1;
    dqoe_d = 1'b0;
    dqo_d = fl_dq_out;
    if (reg_wr && reg_addr == REG_ADDR) begin
      addr_d = reg_wdata[ADDR_W-1:0];
    end
    if (reg_wr && reg_addr == REG_DATA) begin
      exp_d = reg_wdata[DATA_W-1:0];
    end
    case (state_q)
      S_IDLE: begin
        if (reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_RESET]) begin
          state_d = S_WRRST;
          cnt_d = STROBE_CNT;
          fail_d = 1'b0;
        end else if (reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_START]) begin
          // each start begins with a fresh double read
          state_d = S_RD1;
          mode_d = reg_wdata[CTRL_MODE];
          cnt_d = STROBE_CNT;
          done_d = 1'b0;
          fail_d = 1'b0;
          two_d = 1'b0;
        end
      end
      S_RD1, S_RD2, S_RD3: begin
        // reads framed by chip select and output strobe together
        ce_d = strobe_end;
        oe_d = strobe_end;
        if (strobe_end) begin
          last_d = fl_dq_in;
          first_d = fl_dq_in;
          // at least two reads before any timeout verdict
          two_d = (state_q != S_RD1);
          state_d = S_GAP;
          cnt_d = GAP_CNT;
          if (state_q == S_RD1) begin
            mode_d = mode_q;
          end else if (mode_q) begin
            // data polling, re-read after timeout bit seen
            if (poll_true && state_q == S_RD3) begin
              done_d = 1'b1;
              state_d = S_DONE;
            end else if (fl_dq_in[TIMEOUT_BIT] && state_q == S_RD3) begin
              fail_d = 1'b1;
              state_d = S_FAIL;
            end
          end else if (tgl_same) begin
            done_d = 1'b1;
            state_d = S_DONE;
          end else if (state_q == S_RD3) begin
            fail_d = 1'b1;
            state_d = S_FAIL;
          end
        end
      end
      S_GAP: begin
        if (strobe_end) begin
          cnt_d = STROBE_CNT;
          if (done_q) begin
            state_d = S_DONE;
          end else if (mode_q && last_q[POLL_BIT] == exp_q[POLL_BIT]) begin
            // poll bit true: one more read for the full byte
            state_d = S_RD3;
          end else if (!mode_q && two_q && last_q[TIMEOUT_BIT]) begin
            state_d = S_RD3;
          end else if (mode_q && two_q && last_q[TIMEOUT_BIT]) begin
            state_d = S_RD3;
          end else begin
            state_d = S_RD2;
          end
        end
      end
      S_DONE, S_FAIL: begin
        state_d = S_IDLE;
      end
      S_WRRST: begin
        // single write cycle of reset code to any address
        ce_d = strobe_end;
        we_d = strobe_end;
        dqoe_d = !strobe_end;
        dqo_d = RESET_CODE;
        if (strobe_end) begin
          state_d = S_IDLE;
        end
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end

  always_comb begin
    rdata_d = 32'h0;
    case (reg_addr)
      REG_CTRL: rdata_d[CTRL_MODE] = mode_q;
      REG_ADDR: rdata_d[ADDR_W-1:0] = addr_q;
      REG_DATA: rdata_d[DATA_W-1:0] = exp_q;
      REG_STATUS: begin
        rdata_d[ST_BUSY] = (state_q != S_IDLE);
        rdata_d[ST_DONE] = done_q;
        rdata_d[ST_FAIL] = fail_q;
        rdata_d[ST_RDY] = rdy_q;
      end
      REG_LAST: rdata_d[DATA_W-1:0] = last_q;
      default: rdata_d = 32'h0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      cnt_q <= CNT_ZERO;
      addr_q <= '0;
      exp_q <= '0;
      first_q <= '0;
      last_q <= '0;
      mode_q <= 1'b0;
      done_q <= 1'b0;
      fail_q <= 1'b0;
      two_q <= 1'b0;
      rdy_q <= 1'b0;
      reg_rdata <= 32'h0;
      fl_addr <= '0;
      fl_dq_out <= '0;
      fl_dq_oe <= 1'b0;
      fl_ce_n <= 1'b1;
      fl_oe_n <= 1'b1;
      fl_we_n <= 1'b1;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      addr_q <= addr_d;
      exp_q <= exp_d;
      first_q <= first_d;
      last_q <= last_d;
      mode_q <= mode_d;
      done_q <= done_d;
      fail_q <= fail_d;
      two_q <= two_d;
      rdy_q <= ready_busy_n;
      reg_rdata <= reg_rd ? rdata_d : 32'h0;
      // status reads at the program or erase-sector address
      fl_addr <= addr_q;
      fl_dq_out <= dqo_d;
      fl_dq_oe <= dqoe_d;
      fl_ce_n <= ce_d;
      fl_oe_n <= oe_d;
      fl_we_n <= we_d;
    end
  end

  reset_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !fl_we_n |-> fl_dq_oe && fl_dq_out == RESET_CODE && !fl_ce_n)
    else $error("reset write without reset code");
  read_no_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !fl_oe_n |-> fl_we_n && !fl_dq_oe && !fl_ce_n)
    else $error("read strobe with write active");
  fail_after_three_a: assert property (@(posedge mclk) disable iff (!rst_n)
    state_q == S_FAIL |-> $past(state_q) == S_RD3)
    else $error("failure without recheck");
  restart_double_a: assert property (@(posedge mclk) disable iff (!rst_n)
    state_q == S_IDLE && state_d == S_RD1 |=> ##[1:8] !fl_oe_n)
    else $error("start without first read");
  addr_held_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !fl_oe_n && !$past(fl_oe_n) |-> $stable(fl_addr))
    else $error("address moved during read");
  done_needs_reread_a: assert property (@(posedge mclk) disable iff (!rst_n)
    mode_q && state_q == S_DONE |-> $past(state_q, 2) == S_RD3 || $past(state_q) == S_RD3)
    else $error("poll done without reread");

  gap_strobes_high_a: assert property (@(posedge mclk) disable iff (!rst_n)
    state_q == S_GAP |-> fl_ce_n && fl_oe_n)
    else $error("strobe low in gap");
  idle_bus_quiet_a: assert property (@(posedge mclk) disable iff (!rst_n)
    state_q == S_IDLE |-> fl_ce_n && fl_oe_n && fl_we_n && !fl_dq_oe)
    else $error("bus active while idle");
  read_length_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(fl_oe_n) |-> !fl_oe_n [*6] ##1 fl_oe_n)
    else $error("read strobe length wrong");
  write_length_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(fl_we_n) |-> !fl_we_n [*6] ##1 fl_we_n)
    else $error("reset write length wrong");
  gap_length_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(fl_oe_n) |-> fl_oe_n [*4])
    else $error("gap between reads too short");
  oe_with_ce_a: assert property (@(posedge mclk) disable iff (!rst_n)
    fl_we_n |-> fl_oe_n == fl_ce_n)
    else $error("read not framed by both strobes");
  dq_drive_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
    fl_we_n == !fl_dq_oe)
    else $error("data driven outside reset write");
  fail_needs_timeout_a: assert property (@(posedge mclk) disable iff (!rst_n)
    state_q == S_FAIL |-> last_q[TIMEOUT_BIT])
    else $error("failure without timeout bit");
  done_poll_true_a: assert property (@(posedge mclk) disable iff (!rst_n)
    mode_q && state_q == S_DONE |-> last_q[POLL_BIT] == exp_q[POLL_BIT])
    else $error("poll done with wrong bit");
  recheck_two_reads_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !mode_q && state_q == S_RD3 |-> two_q)
    else $error("recheck before two reads");
  ready_follows_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(rst_n) |-> rdy_q == $past(ready_busy_n))
    else $error("ready status not tracking line");
  start_clears_a: assert property (@(posedge mclk) disable iff (!rst_n)
    state_q == S_RD1 && $past(state_q) == S_IDLE |-> !done_q && !fail_q)
    else $error("stale result at start");
  mode_held_a: assert property (@(posedge mclk) disable iff (!rst_n)
    state_q != S_IDLE && $past(state_q) != S_IDLE |-> $stable(mode_q))
    else $error("mode changed during polling");

endmodule

// ==== verif/flash_model.sv ====
`timescale 1ns/1ps
module flash_model
  import flash_status_pkg::*;
(
  // flash pins
  input wire logic [DATA_W-1:0] dq_in,
  input wire logic dq_oe,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  output logic [DATA_W-1:0] dq,
  output logic rb_low,
  // operation setup
  input wire logic load,
  input wire logic [3:0] n_busy,
  input wire logic fail,
  input wire logic erase,
  input wire logic [7:0] prog
);
  int left = 0;
  logic tfail = 1'b0;
  logic tgl = 1'b0;
  logic [7:0] last = 8'h00;
  logic [7:0] wdat = 8'h00;
  logic [7:0] st;
  logic busy;
  wire rd = !ce_n && !oe_n && we_n;
  wire wr = !ce_n && !we_n;
  assign busy = (left > 0) || tfail;
  assign rb_low = busy;
  assign st = {erase ? 1'b0 : ~prog[7], tgl, tfail, 1'b0, erase, erase & tgl, 2'b00};
  assign dq = rd ? (busy ? st : prog) : ~last;
  always @(posedge load) begin
    left = n_busy;
    tfail = fail;
  end
  always @(negedge rd) begin
    last = busy ? st : prog;
    if (busy) tgl = ~tgl;
    if (left > 0) left = left - 1;
  end
  always @(wr or dq_in) if (wr && dq_oe) wdat = dq_in;
  always @(negedge wr) if (wdat == RESET_CODE) begin
    tfail = 1'b0;
    left = 0;
  end
endmodule

// ==== verif/flash_status_poller_test.sv ====
`timescale 1ns/1ps
module flash_status_poller_test;
  import flash_status_pkg::*;
  logic mclk = 0;
  logic rst_n = 0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 0;
  logic reg_rd = 0;
  logic [31:0] reg_rdata;
  logic [ADDR_W-1:0] fl_addr;
  logic [DATA_W-1:0] fl_dq_out, mdq;
  logic fl_dq_oe, fl_ce_n, fl_oe_n, fl_we_n, rb_low;
  logic load = 0, fail_i = 0, erase_i = 0;
  logic [3:0] n_busy = 4'h0;
  logic [7:0] prog = 8'h00;
  int n_mismatch = 0;
  int checked = 0;
  logic [31:0] seed = 32'h934320ED;
  wire [DATA_W-1:0] fl_dq_in = fl_dq_oe ? fl_dq_out : mdq;
  wire ready_busy_n = rb_low ? 1'b0 : 1'b1;
  always #5 mclk = ~mclk;
  flash_status_poller dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .fl_addr(fl_addr), .fl_dq_in(fl_dq_in), .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe),
    .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n), .ready_busy_n(ready_busy_n));
  flash_model mdl (.dq_in(fl_dq_out), .dq_oe(fl_dq_oe), .ce_n(fl_ce_n), .oe_n(fl_oe_n),
    .we_n(fl_we_n), .dq(mdq), .rb_low(rb_low), .load(load), .n_busy(n_busy),
    .fail(fail_i), .erase(erase_i), .prog(prog));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic results();
    $display("mismatches %0d checked %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk) begin reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1; end
    @(posedge mclk) reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk) begin reg_addr <= a; reg_rd <= 1'b1; end
    @(posedge mclk) reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic wait_idle(output logic [31:0] d);
    int i;
    for (i = 0; i < 3000; i++) begin
      rd(REG_STATUS, d);
      if (d[ST_BUSY] === 1'b0) return;
    end
    n_mismatch++;
    results();
  endtask
  task automatic run(input logic m, input int n, input logic f, input logic e);
    logic [31:0] a, d;
    a = xs() & 32'hFFFFF;
    @(posedge mclk) begin
      n_busy <= 4'(n); fail_i <= f; erase_i <= e; load <= 1'b1;
      prog <= e ? 8'hFF : xs() & 32'hFF;
    end
    @(posedge mclk) load <= 1'b0;
    wr(REG_ADDR, a);
    wr(REG_DATA, {24'h0, prog});
    wr(REG_CTRL, {30'h0, m, 1'b1});
    rd(REG_STATUS, d);
    cmp(d[ST_BUSY], 1'b1);
    cmp(d[ST_RDY], (n == 0 && !f) ? 1'b1 : 1'b0);
    wait_idle(d);
    cmp(d[3:0], {!f, f, !f, 1'b0});
    cmp({12'h0, fl_addr}, a);
    if (!f) begin
      rd(REG_LAST, d);
      cmp(d, {24'h0, prog});
    end else begin
      wr(REG_CTRL, 32'h4);
      wait_idle(d);
      repeat (4) @(posedge mclk);
      rd(REG_STATUS, d);
      cmp(d[ST_RDY], 1'b1);
    end
  endtask
  initial begin
    logic [31:0] d;
    int k;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    rd(4'hF, d);
    cmp(d, 32'h0);
    for (k = 0; k < 8; k++) run(k[0], k[2] ? 0 : 1 + xs() % 6, k[1], k[2]);
    run(1'b0, 15, 1'b0, 1'b0);
    rd(REG_CTRL, d);
    cmp(d[CTRL_MODE], 1'b0);
    results();
  end
endmodule
